// ---- hdl/alarm_unit_pkg.sv ----
package alarm_unit_pkg;
    // ==================================================================
    // Sizes
    localparam int NUM_ALARMS   = 4;
    localparam int VALUE_W      = 16;
    localparam int TIME_W       = 13;
    localparam int FUNC_W       = 3;
    localparam int SEG_W        = 4;
    // ==================================================================
    // Timing
    localparam int CLK_HZ       = 40_000_000;
    localparam int SECOND_CYC   = CLK_HZ;
    localparam logic [TIME_W-1:0] TIME_MAX = 13'h1964; // 6500 s
    // ==================================================================
    // Alarm functions
    localparam logic [FUNC_W-1:0] FN_OFF        = 3'h0;
    localparam logic [FUNC_W-1:0] FN_INPUT_FLT  = 3'h1;
    localparam logic [FUNC_W-1:0] FN_SEGMENT    = 3'h2;
    localparam logic [FUNC_W-1:0] FN_ABS_LOW    = 3'h3;
    localparam logic [FUNC_W-1:0] FN_ABS_HIGH   = 3'h4;
    localparam logic [FUNC_W-1:0] FN_DEV_BAND   = 3'h5;
    localparam logic [FUNC_W-1:0] FN_DEV_LOW    = 3'h6;
    localparam logic [FUNC_W-1:0] FN_DEV_HIGH   = 3'h7;
    // ==================================================================
    // Register offsets (APB byte addresses)
    localparam logic [7:0] REG_CTRL      = 8'h00;
    localparam logic [7:0] REG_STATUS    = 8'h04;
    localparam logic [7:0] REG_SETPOINT  = 8'h08;
    localparam logic [7:0] REG_CFG_BASE  = 8'h10;
    localparam logic [7:0] REG_THR_BASE  = 8'h20;
    localparam logic [7:0] REG_TIME_BASE = 8'h30;
    // CFG field positions: func[2:0], blocking[3], event segment mask[31:16]
    localparam int CFG_BLOCK_BIT = 3;
    localparam int CFG_SEG_LSB   = 16;
    // TIME fields: on_time[12:0], off_or_delay_time[28:16]
    localparam int TIME_OFF_LSB  = 16;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
endpackage

// ---- hdl/process_alarm_unit.sv ----
// How it works
// - Four alarm channels, each with own function, threshold, timers and output.
// - Each alarm compares against its own threshold or deviation value.
// - Function off never asserts the alarm or its output.
// - Input fault alarm asserts on interrupted, out-of-range or shorted sensor.
// - Segment event alarm asserts while a program segment enabled for it runs.
// - Absolute low asserts while process value is below threshold.
// - Absolute high asserts while process value is above threshold.
// - Band with positive deviation asserts outside setpoint plus/minus deviation.
// - Band with negative deviation asserts inside that band.
// - Deviation low asserts below setpoint minus signed deviation.
// - Deviation high asserts above setpoint plus signed deviation.
// - Two timers shape output: follow, delayed on, or repetitive pulses.
// - On time only: one pulse of on time at the alarm event.
// - Lamps show the recognised condition, not the timed output.
// - Blocking hides a condition present at start-up or after run falls.
// - Blocked alarm recognised only after condition goes inactive then active.
// - Blocking never applies to the input fault function.
// - Run input open forces all control and alarm outputs off.
`timescale 1ns/100ps
`default_nettype none
module process_alarm_unit #(
    parameter int SECOND_CYCLES = alarm_unit_pkg::SECOND_CYC
) (
    input  wire logic                                   pclk,
    input  wire logic                                   presetn,
    input  wire logic                                   psel,
    input  wire logic                                   penable,
    input  wire logic                                   pwrite,
    input  wire logic [7:0]                             paddr,
    input  wire logic [31:0]                            pwdata,
    output logic      [31:0]                            prdata,
    output logic                                        pready,
    output logic                                        pslverr,
    input  wire logic signed [alarm_unit_pkg::VALUE_W-1:0] process_value,
    input  wire logic                                   sample_valid,
    input  wire logic                                   sensor_open,
    input  wire logic                                   sensor_range,
    input  wire logic                                   sensor_short,
    input  wire logic                                   program_running,
    input  wire logic [alarm_unit_pkg::SEG_W-1:0]       program_segment,
    input  wire logic                                   run_pin,
    input  wire logic                                   control_request,
    output logic                                        control_out,
    output logic [alarm_unit_pkg::NUM_ALARMS-1:0]       alarm_out,
    output logic [alarm_unit_pkg::NUM_ALARMS-1:0]       alarm_lamp
);
    import alarm_unit_pkg::*;

    // ==================================================================
    // Pin synchronisers
    logic [1:0] run_sync_r;
    logic [2:0] flt_meta_r;
    logic [2:0] flt_sync_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_sync_r <= 2'h0;
            flt_meta_r <= 3'h0;
            flt_sync_r <= 3'h0;
        end else begin
            run_sync_r <= {run_sync_r[0], run_pin};
            flt_meta_r <= {sensor_open, sensor_range, sensor_short};
            flt_sync_r <= flt_meta_r;
        end
    end
    wire logic run_ok = run_sync_r[1];
    logic      run_d_r;
    wire logic input_fault = |flt_sync_r;

    // ==================================================================
    // Register file
    logic                      run_use_r;
    logic signed [VALUE_W-1:0] setpoint_r;
    logic [31:0]               cfg_r     [NUM_ALARMS];
    logic signed [VALUE_W-1:0] thr_r     [NUM_ALARMS];
    logic [TIME_W-1:0]         on_t_r    [NUM_ALARMS];
    logic [TIME_W-1:0]         off_t_r   [NUM_ALARMS];
    logic [NUM_ALARMS-1:0]     cond_r;
    logic [NUM_ALARMS-1:0]     recog;

    wire logic wr_en = psel && penable && pwrite;
    wire logic [1:0] idx = paddr[3:2];
    wire logic time_wr = wr_en && paddr[7:4] == REG_TIME_BASE[7:4];

    function automatic logic [TIME_W-1:0] clamp_t(input logic [15:0] v);
        clamp_t = (v > 16'(TIME_MAX)) ? TIME_MAX : v[TIME_W-1:0];
    endfunction

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_use_r  <= 1'b0;
            setpoint_r <= '0;
            for (int i = 0; i < NUM_ALARMS; i++) begin
                cfg_r[i]   <= '0;
                thr_r[i]   <= '0;
                on_t_r[i]  <= '0;
                off_t_r[i] <= '0;
            end
        end else if (wr_en) begin
            if (paddr == REG_CTRL) begin
                run_use_r <= pwdata[0];
            end else if (paddr == REG_SETPOINT) begin
                setpoint_r <= pwdata[VALUE_W-1:0];
            end else if (paddr[7:4] == REG_CFG_BASE[7:4]) begin
                cfg_r[idx] <= pwdata;
            end else if (paddr[7:4] == REG_THR_BASE[7:4]) begin
                thr_r[idx] <= pwdata[VALUE_W-1:0];
            end else if (paddr[7:4] == REG_TIME_BASE[7:4]) begin
                on_t_r[idx]  <= clamp_t(pwdata[15:0]);
                off_t_r[idx] <= clamp_t(pwdata[TIME_OFF_LSB +: 16]);
            end
        end
    end

    logic [31:0] rd_nxt;
    logic        err_nxt;
    always_comb begin
        rd_nxt  = 32'h0000_0000;
        err_nxt = 1'b0;
        if (paddr == REG_CTRL) begin
            rd_nxt = {31'h0, run_use_r};
        end else if (paddr == REG_STATUS) begin
            rd_nxt = {16'h0, 4'h0, alarm_out, recog, cond_r};
            rd_nxt[31] = run_ok;
        end else if (paddr == REG_SETPOINT) begin
            rd_nxt = 32'(setpoint_r);
        end else if (paddr[7:4] == REG_CFG_BASE[7:4]) begin
            rd_nxt = cfg_r[idx];
        end else if (paddr[7:4] == REG_THR_BASE[7:4]) begin
            rd_nxt = 32'(thr_r[idx]);
        end else if (paddr[7:4] == REG_TIME_BASE[7:4]) begin
            rd_nxt = {3'h0, off_t_r[idx], 3'h0, on_t_r[idx]};
        end else begin
            err_nxt = 1'b1;
        end
    end

    // Zero-wait slave: pready is a flop so outputs stay registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && err_nxt;
            if (psel && !penable && !pwrite) begin
                prdata <= rd_nxt;
            end
        end
    end

    // ==================================================================
    // Condition evaluation
    wire logic outputs_on = !run_use_r || run_ok;
    wire logic run_fall   = run_use_r && run_d_r && !run_ok;

    // One-second tick shared by all timers
    logic [31:0] sec_cnt_r;
    logic        sec_tick;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sec_cnt_r <= '0;
            run_d_r   <= 1'b0;
        end else begin
            run_d_r   <= run_ok;
            sec_cnt_r <= (sec_cnt_r >= 32'(SECOND_CYCLES - 1)) ? 32'h0 : sec_cnt_r + 32'h1;
        end
    end
    assign sec_tick = (sec_cnt_r == 32'(SECOND_CYCLES - 1));

    logic [NUM_ALARMS-1:0] cond_nxt;
    logic [NUM_ALARMS-1:0] blocked_r;
    logic                  first_r;
    always_comb begin
        logic signed [VALUE_W+1:0] pv;
        logic signed [VALUE_W+1:0] sp;
        logic signed [VALUE_W+1:0] th;
        logic signed [VALUE_W+1:0] mag;
        pv  = '0;
        sp  = '0;
        th  = '0;
        mag = '0;
        cond_nxt = '0;
        for (int i = 0; i < NUM_ALARMS; i++) begin
            pv  = (VALUE_W+2)'(process_value);
            sp  = (VALUE_W+2)'(setpoint_r);
            th  = (VALUE_W+2)'(thr_r[i]);
            mag = (th < 0) ? -th : th;
            case (cfg_r[i][FUNC_W-1:0])
                FN_OFF:       cond_nxt[i] = 1'b0;
                FN_INPUT_FLT: cond_nxt[i] = input_fault;
                FN_SEGMENT:   cond_nxt[i] = program_running
                                  && cfg_r[i][CFG_SEG_LSB + 32'(program_segment)];
                FN_ABS_LOW:   cond_nxt[i] = pv < th;
                FN_ABS_HIGH:  cond_nxt[i] = pv > th;
                FN_DEV_BAND:  begin
                    if (th >= 0) begin
                        cond_nxt[i] = (pv < sp - mag) || (pv > sp + mag);
                    end else begin
                        cond_nxt[i] = (pv > sp - mag) && (pv < sp + mag);
                    end
                end
                FN_DEV_LOW:   cond_nxt[i] = pv < sp - th;
                FN_DEV_HIGH:  cond_nxt[i] = pv > sp + th;
                default:      cond_nxt[i] = 1'b0;
            endcase
        end
    end

    // Condition sampled only on sample updates
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cond_r  <= '0;
            first_r <= 1'b1;
        end else if (sample_valid) begin
            cond_r  <= cond_nxt;
            first_r <= 1'b0;
        end
    end

    // Blocking: armed at start-up and on run falling, freed once inactive
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blocked_r <= '0;
        end else begin
            for (int i = 0; i < NUM_ALARMS; i++) begin
                if (!cfg_r[i][CFG_BLOCK_BIT]
                    || cfg_r[i][FUNC_W-1:0] == FN_INPUT_FLT) begin
                    blocked_r[i] <= 1'b0;
                end else if ((first_r && sample_valid && cond_nxt[i])
                             || (run_fall && cond_r[i])) begin
                    blocked_r[i] <= 1'b1;
                end else if (!cond_r[i]) begin
                    blocked_r[i] <= 1'b0;
                end
            end
        end
    end
    assign recog = cond_r & ~blocked_r;

    // ==================================================================
    // Output timers
    typedef enum logic [3:0] {
        T_IDLE  = 4'b0001,
        T_ON    = 4'b0010,
        T_OFF   = 4'b0100,
        T_DONE  = 4'b1000
    } tmr_e;
    tmr_e              st_r  [NUM_ALARMS];
    logic [TIME_W-1:0] cnt_r [NUM_ALARMS];
    logic [NUM_ALARMS-1:0] drive;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_ALARMS; i++) begin
                st_r[i]  <= T_IDLE;
                cnt_r[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NUM_ALARMS; i++) begin
                // Retime restarts timing, so a finished delay cannot switch on at once
                if (!recog[i] || (time_wr && idx == 2'(i))) begin
                    st_r[i]  <= T_IDLE;
                    cnt_r[i] <= '0;
                end else begin
                    case (st_r[i])
                        T_IDLE: begin
                            if (on_t_r[i] != '0) begin
                                st_r[i]  <= T_ON;
                                cnt_r[i] <= on_t_r[i];
                            end else if (off_t_r[i] != '0) begin
                                st_r[i]  <= T_OFF;
                                cnt_r[i] <= off_t_r[i];
                            end
                        end
                        T_ON: begin
                            if (sec_tick) begin
                                if (cnt_r[i] > 13'h0001) begin
                                    cnt_r[i] <= cnt_r[i] - 13'h0001;
                                end else if (off_t_r[i] != '0) begin
                                    st_r[i]  <= T_OFF;
                                    cnt_r[i] <= off_t_r[i];
                                end else begin
                                    st_r[i]  <= T_DONE;
                                end
                            end
                        end
                        T_OFF: begin
                            if (sec_tick) begin
                                if (cnt_r[i] > 13'h0001) begin
                                    cnt_r[i] <= cnt_r[i] - 13'h0001;
                                end else if (on_t_r[i] != '0) begin
                                    st_r[i]  <= T_ON;
                                    cnt_r[i] <= on_t_r[i];
                                end else begin
                                    st_r[i]  <= T_DONE;
                                end
                            end
                        end
                        T_DONE:  st_r[i] <= T_DONE;
                        default: st_r[i] <= T_IDLE;
                    endcase
                end
            end
        end
    end

    // Delay mode holds on in T_DONE; single pulse mode stays off there
    always_comb begin
        for (int i = 0; i < NUM_ALARMS; i++) begin
            if (on_t_r[i] == '0 && off_t_r[i] == '0) begin
                drive[i] = recog[i];
            end else if (on_t_r[i] == '0) begin
                drive[i] = recog[i] && st_r[i] == T_DONE;
            end else begin
                drive[i] = recog[i] && st_r[i] == T_ON;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_out   <= '0;
            alarm_lamp  <= '0;
            control_out <= 1'b0;
        end else begin
            alarm_out   <= outputs_on ? drive : '0;
            alarm_lamp  <= recog;
            control_out <= outputs_on && control_request;
        end
    end
endmodule
`default_nettype wire

// ---- test/alarm_unit_properties.sv ----
`timescale 1ns/100ps
`default_nettype none
module alarm_unit_checker (
    input wire logic                              pclk,
    input wire logic                              presetn,
    input wire logic                              psel,
    input wire logic                              penable,
    input wire logic                              pwrite,
    input wire logic [7:0]                        paddr,
    input wire logic [31:0]                       pwdata,
    input wire logic [31:0]                       prdata,
    input wire logic                              pready,
    input wire logic                              pslverr,
    input wire logic                              sample_valid,
    input wire logic                              run_pin,
    input wire logic                              control_request,
    input wire logic                              control_out,
    input wire logic [alarm_unit_pkg::NUM_ALARMS-1:0] alarm_out,
    input wire logic [alarm_unit_pkg::NUM_ALARMS-1:0] alarm_lamp
);
    import alarm_unit_pkg::*;
    logic run_used_r;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Mirror of run-in-use; the stop check is void without it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_used_r <= 1'b0;
        end else if (psel && penable && pready && pwrite && paddr == REG_CTRL) begin
            run_used_r <= pwdata[0];
        end
    end
    // ==================================================================
    // Bus and alarm relations
    zero_wait_a: assert property (psel && !penable |=> pready)
        else $error("access phase without ready");
    ready_access_a: assert property (pready |-> psel && penable)
        else $error("ready outside access phase");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    err_data_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
        else $error("refused read data not zero");
    lamp_on_sample_a: assert property (
        |(alarm_lamp & ~$past(alarm_lamp)) |-> $past(sample_valid, 2))
        else $error("lamp rose without a sample");
    out_needs_lamp_a: assert property (
        (alarm_out & ~$past(alarm_out) & ~alarm_lamp) == '0)
        else $error("output rose without recognised alarm");
    control_gate_a: assert property (
        control_out |-> control_request || $past(control_request) || $past(control_request, 2))
        else $error("control output without request");
    stop_forces_off_a: assert property (
        (run_used_r && !run_pin) [*4] |=> !control_out && alarm_out == '0)
        else $error("outputs on while run open");
    cover property (|(alarm_lamp & ~$past(alarm_lamp)));
    cover property (pready && pslverr);
    cover property ($rose(alarm_out[0]));
endmodule
bind process_alarm_unit alarm_unit_checker checker_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .sample_valid, .run_pin, .control_request, .control_out, .alarm_out,
    .alarm_lamp
);
`default_nettype wire

// ---- test/front_end_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module front_end_model (
    input  wire logic                                     pclk,
    output logic signed [alarm_unit_pkg::VALUE_W-1:0]     process_value,
    output logic                                          sample_valid,
    output logic                                          sensor_open,
    output logic                                          sensor_range,
    output logic                                          sensor_short
);
    import alarm_unit_pkg::*;
    initial begin
        process_value = '0;
        sample_valid = 1'b0;
        sensor_open = 1'b0;
        sensor_range = 1'b0;
        sensor_short = 1'b0;
    end
    // One-cycle sample strobe, value held until the next one
    task automatic send(input logic [VALUE_W-1:0] v);
        @(posedge pclk);
        process_value <= v;
        sample_valid <= 1'b1;
        @(posedge pclk);
        sample_valid <= 1'b0;
    endtask
    // Flags pass two sync flops, so settle before any sample
    task automatic set_fault(input logic [2:0] f);
        @(posedge pclk);
        sensor_open <= f[0];
        sensor_range <= f[1];
        sensor_short <= f[2];
        repeat (3) @(posedge pclk);
    endtask
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import alarm_unit_pkg::*;
    localparam int SEC = 10;
    typedef struct {logic [2:0] fn; logic [15:0] thr; logic [15:0] pv; logic exp;} row_s;
    // ==================================================================
    // Signals
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [15:0] process_value;
    logic        sample_valid;
    logic        sensor_open;
    logic        sensor_range;
    logic        sensor_short;
    logic        program_running = 1'b0;
    logic [3:0]  program_segment = 4'h0;
    logic        run_pin = 1'b1;
    logic        control_request = 1'b0;
    logic        control_out;
    logic [3:0]  alarm_out;
    logic [3:0]  alarm_lamp;
    logic [31:0] rd_q;
    logic        rd_e;
    logic        prev;
    int          c;
    int          rises;
    int          cycles = 0;
    int          n_errors = 0;
    int          samples_checked = 0;
    row_s rows [14] = '{ // setpoint 100
        '{FN_OFF, 16'h0000, 16'h01F4, 1'b0},
        '{FN_ABS_LOW, 16'h0032, 16'h0031, 1'b1},
        '{FN_ABS_LOW, 16'h0032, 16'h0032, 1'b0},
        '{FN_ABS_HIGH, 16'h0032, 16'h0033, 1'b1},
        '{FN_ABS_HIGH, 16'h0032, 16'h0032, 1'b0},
        '{FN_DEV_BAND, 16'h000A, 16'h006F, 1'b1},
        '{FN_DEV_BAND, 16'h000A, 16'h006E, 1'b0},
        '{FN_DEV_BAND, 16'h000A, 16'h0059, 1'b1},
        '{FN_DEV_BAND, 16'hFFF6, 16'h0069, 1'b1},
        '{FN_DEV_BAND, 16'hFFF6, 16'h0078, 1'b0},
        '{FN_DEV_LOW, 16'h000A, 16'h0059, 1'b1},
        '{FN_DEV_LOW, 16'h000A, 16'h005A, 1'b0},
        '{FN_DEV_HIGH, 16'hFFF6, 16'h005B, 1'b1},
        '{FN_DEV_HIGH, 16'hFFF6, 16'h005A, 1'b0}
    };
    always #12.5 pclk = ~pclk;
    process_alarm_unit #(.SECOND_CYCLES(SEC)) process_alarm_unit_i (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .process_value, .sample_valid, .sensor_open, .sensor_range,
        .sensor_short, .program_running, .program_segment, .run_pin, .control_request,
        .control_out, .alarm_out, .alarm_lamp
    );
    front_end_model front_end_model_i (
        .pclk, .process_value, .sample_valid, .sensor_open, .sensor_range, .sensor_short
    );
    // ==================================================================
    // Tasks
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd_q = prdata;
        rd_e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic smp(input logic [15:0] v);
        front_end_model_i.send(v);
        repeat (3) @(posedge pclk);
    endtask
    task automatic wait_out(input int n, input logic v, output int k);
        k = 0;
        while (alarm_out[n] !== v && k < 200) begin
            @(posedge pclk);
            k++;
        end
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input int v, input int lo, input int hi);
        samples_checked++;
        if (v < lo || v > hi) begin
            n_errors++;
            $display("mismatch t=%0t got=%h exp=%h..%h", $time, v, lo, hi);
        end
    endtask
    task automatic conclude();
        $display("checked=%0d errors=%0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Ceiling well above the few hundred cycles the run needs
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            conclude();
        end
    end
    // ==================================================================
    // Sequence
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        control_request <= 1'b1;
        apb(1'b1, REG_SETPOINT, 32'h0000_0064);
        for (int i = 0; i < 14; i++) begin
            apb(1'b1, REG_CFG_BASE + 8'(4 * (i % 4)), {29'h0, rows[i].fn});
            apb(1'b1, REG_THR_BASE + 8'(4 * (i % 4)), {16'h0, rows[i].thr});
            smp(rows[i].pv);
            chk(alarm_lamp[i % 4], rows[i].exp);
            chk(alarm_out[i % 4], rows[i].exp);
        end
        apb(1'b1, REG_CFG_BASE + 8'h04, 32'h0000_0009);
        for (int f = 0; f < 3; f++) begin
            front_end_model_i.set_fault(3'(1 << f));
            smp(16'h0000);
            chk(alarm_lamp[1], 1'b1);
            front_end_model_i.set_fault(3'b000);
            smp(16'h0000);
            chk(alarm_lamp[1], 1'b0);
        end
        apb(1'b1, REG_CFG_BASE + 8'h08, 32'h0008_0002);
        program_running <= 1'b1;
        program_segment <= 4'h3;
        smp(16'h0000);
        chk(alarm_lamp[2], 1'b1);
        program_segment <= 4'h2;
        smp(16'h0000);
        chk(alarm_lamp[2], 1'b0);
        program_running <= 1'b0;
        program_segment <= 4'h3;
        smp(16'h0000);
        chk(alarm_lamp[2], 1'b0);
        apb(1'b1, REG_CFG_BASE + 8'h0C, 32'h0000_000C);
        apb(1'b1, REG_THR_BASE + 8'h0C, 32'h0000_0000);
        apb(1'b1, REG_CTRL, 32'h0000_0001);
        front_end_model_i.set_fault(3'b100);
        smp(16'h000A);
        chk(alarm_lamp[3], 1'b1);
        run_pin <= 1'b0;
        repeat (6) @(posedge pclk);
        chk({control_out, alarm_out}, 32'h0000_0000);
        run_pin <= 1'b1;
        repeat (6) @(posedge pclk);
        chk(control_out, 1'b1);
        control_request <= 1'b0;
        repeat (2) @(posedge pclk);
        chk(control_out, 1'b0);
        control_request <= 1'b1;
        smp(16'h000A);
        chk(alarm_lamp[3], 1'b0);
        chk(alarm_lamp[1], 1'b1);
        smp(16'hFFFB);
        smp(16'h000A);
        chk(alarm_lamp[3], 1'b1);
        front_end_model_i.set_fault(3'b000);
        apb(1'b1, REG_CFG_BASE, 32'h0000_0004);
        apb(1'b1, REG_THR_BASE, 32'h0000_0000);
        apb(1'b1, REG_TIME_BASE, 32'h0000_0003);
        smp(16'hFFFB);
        front_end_model_i.send(16'h0005);
        wait_out(0, 1'b1, c);
        chk_rng(c, 0, 4);
        wait_out(0, 1'b0, c);
        chk_rng(c, 2 * SEC - 2, 3 * SEC + 2);
        chk(alarm_lamp[0], 1'b1);
        apb(1'b1, REG_TIME_BASE, 32'h0002_0000);
        smp(16'hFFFB);
        front_end_model_i.send(16'h0005);
        wait_out(0, 1'b1, c);
        chk_rng(c, SEC - 2, 2 * SEC + 4);
        apb(1'b1, REG_TIME_BASE, 32'h0001_0001);
        smp(16'hFFFB);
        front_end_model_i.send(16'h0005);
        rises = 0;
        prev = 1'b0;
        repeat (100) begin
            @(posedge pclk);
            if (alarm_out[0] === 1'b1 && prev === 1'b0) rises++;
            prev = alarm_out[0];
        end
        chk_rng(rises, 4, 6);
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        chk({control_out, alarm_out, alarm_lamp}, 32'h0000_0000);
        presetn <= 1'b1;
        apb(1'b0, REG_CTRL, 32'h0000_0000);
        chk(rd_q, CTRL_RESET);
        apb(1'b0, 8'hFC, 32'h0000_0000);
        chk(rd_q, 32'h0000_0000);
        chk(rd_e, 1'b1);
        conclude();
    end
endmodule
`default_nettype wire
